// ==== rtl/knock_trig_pkg.sv ====
package knock_trig_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] KNOCK_DETECT_CONFIG_ADDR = 8'h47;
  localparam logic [7:0] OVERRANGE_UNDERVOLTAGE_CONFIG_ADDR = 8'h48;
  localparam logic [7:0] CONVERSION_TRIGGER_FILTER_CONFIG_ADDR = 8'h49;
  localparam logic [7:0] KNOCK_DETECT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] OVERRANGE_UNDERVOLTAGE_CONFIG_RESET = 8'h00;
  localparam logic [7:0] CONVERSION_TRIGGER_FILTER_CONFIG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Writable bit masks; all other bits are reserved
  // ----------------------------------------------------------------
  localparam logic [7:0] KNOCK_DETECT_CONFIG_MASK = 8'h07;
  localparam logic [7:0] OVERRANGE_UNDERVOLTAGE_CONFIG_MASK = 8'h1f;
  localparam logic [7:0] CONVERSION_TRIGGER_FILTER_CONFIG_MASK = 8'he7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned KNOCK_AXIS_LSB = 0;
  localparam int unsigned TRIPLE_KNOCK_ENABLE_BIT = 2;
  localparam int unsigned OVERRANGE_OUTPUT_SELECT_LSB = 0;
  localparam int unsigned OVERRANGE_PROTECTION_OFF_BIT = 2;
  localparam int unsigned OVERRANGE_DETECTOR_OFF_BIT = 3;
  localparam int unsigned UNDERVOLTAGE_DETECTOR_OFF_BIT = 4;
  localparam int unsigned CONVERSION_TRIGGER_EXTERNAL_BIT = 0;
  localparam int unsigned CONVERSION_TRIGGER_SOURCE_BIT = 1;
  localparam int unsigned ROUNDING_MODE_BIT = 2;
  localparam int unsigned FIRST_ORDER_RECURSIVE_FILTER_ENABLE_BIT = 5;
  localparam int unsigned FIRST_STAGE_RATE_SELECT_BIT = 6;
  localparam int unsigned SECOND_STAGE_DECIMATOR_BYPASS_BIT = 7;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] KNOCK_AXIS_X = 2'h0;
  localparam logic [1:0] KNOCK_AXIS_Y = 2'h1;
  localparam logic [1:0] KNOCK_AXIS_Z = 2'h2;
  localparam logic [1:0] OVERRANGE_OUT_FULL_SCALE = 2'h0;
  localparam logic [1:0] OVERRANGE_OUT_HOLD = 2'h1;
  localparam logic [1:0] OVERRANGE_OUT_PASS = 2'h2;
  localparam logic [15:0] FULL_SCALE_POSITIVE = 16'h7fff;
  localparam logic [15:0] FULL_SCALE_NEGATIVE = 16'h8000;

  // ----------------------------------------------------------------
  // Decimation figures
  // ----------------------------------------------------------------
  localparam logic [5:0] FIRST_STAGE_RATIO_SLOW = 6'h20;
  localparam logic [5:0] FIRST_STAGE_RATIO_FAST = 6'h10;
  localparam logic [2:0] ODR_FACTOR_DEFAULT = 3'h1;
  localparam logic [2:0] ODR_FACTOR_SECOND_BYPASS = 3'h2;
  localparam logic [2:0] ODR_FACTOR_FAST_FIRST = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned INTERNAL_CONVERSION_PERIOD_NS = 1000;
  localparam int unsigned INTERNAL_CONVERSION_CYCLES =
    (INTERNAL_CONVERSION_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage

// ==== rtl/conversion_tick_divider.sv ====
`timescale 1ns/1ps
module conversion_tick_divider #(
  parameter int unsigned PERIOD_CYCLES = knock_trig_pkg::INTERNAL_CONVERSION_CYCLES
) (
  input logic sys_clk,
  input logic sys_rst,
  input logic enable,
  output logic tick
);
  localparam int unsigned CW = (PERIOD_CYCLES > 1) ? $clog2(PERIOD_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES - 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic tick_reg;
  logic tick_next;

  // Counter restarts whenever the divider is idle, so the first internal
  // start comes a full period after switching back to internal mode
  always_comb
  begin
    count_next = '0;
    tick_next = 1'b0;
    if (enable)
    begin
      if (count_reg == LAST)
      begin
        tick_next = 1'b1;
      end
      else
      begin
        count_next = count_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

// ==== rtl/knock_overrange_trigger_config.sv ====
`timescale 1ns/1ps

// How it works
// (RULE_01) Knock axis field 00, 01, 10 picks X, Y, Z for knock watching.
// (RULE_02) Knock config bit 2 turns triple-knock detection on or off.
// (RULE_03) Overrange config bit 4 set switches the undervoltage detector off.
// (RULE_04) Overrange config bit 3 set disables all overrange detection.
// (RULE_05) Overrange config bit 2 set keeps excitations on during overrange.
// (RULE_06) Overrange output field: full scale with sign, hold last, or pass.
// (RULE_07) No overrange output substitution while output runs in PDM mode.
// (RULE_08) Trigger config bit 7 bypasses second 2x decimator, doubling data rate.
// (RULE_09) Rate bit 0: first stage 32x; rate bit 1: 16x, second stage off.
// (RULE_10) Rate bit set raises data rate fourfold over default.
// (RULE_11) Bit 5 turns equalizer into first-order recursive filter in allowed modes.
// (RULE_12) Rounding bit 0 truncates the high-pass output.
// (RULE_13) Rounding bit 1 adds one to negative truncated values only.
// (RULE_14) Trigger source bit picks frame-sync pin (0) or first interrupt pin (1).
// (RULE_15) External bit 0 makes conversion starts internally, pins ignored.
// (RULE_16) External bit 1 starts conversions on rising edges of selected pin.
// (RULE_17) Knock config sits at 0x47 and resets to 0x00.
// (RULE_18) Reserved bits read zero and ignore writes.
module knock_overrange_trigger_config #(
  parameter int unsigned HPF_WIDTH = 24,
  parameter int unsigned CONVERSION_CYCLES = knock_trig_pkg::INTERNAL_CONVERSION_CYCLES
) (
  input logic sys_clk,
  input logic sys_rst,
  input logic [7:0] regAddr,
  input logic [7:0] regWrData,
  input logic regWrite,
  input logic regRead,
  output logic [7:0] regRdData,
  output logic [2:0] knockAxisSelect,
  output logic tripleKnockEnable,
  output logic undervoltageDetectEnable,
  input logic overrangeRaw,
  output logic overrangeFlag,
  output logic excitationOff,
  input logic pdmMode,
  input logic [15:0] sampleIn,
  input logic sampleValid,
  output logic [15:0] sampleOut,
  output logic sampleOutValid,
  output logic [5:0] firstStageRatio,
  output logic secondStageOn,
  output logic [2:0] odrFactor,
  input logic highPerformanceMode,
  input logic reducedBandwidthMode,
  input logic lowPowerMode,
  input logic equalizerSkip,
  input logic lowpassPathSelect,
  output logic recursiveFilterActive,
  input logic [HPF_WIDTH-1:0] hpfIn,
  input logic hpfValid,
  output logic [15:0] hpfOut,
  output logic hpfOutValid,
  input logic frameSyncPin,
  input logic firstInterruptPin,
  output logic conversionStart
);
  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [7:0] knockCfg_reg;
  logic [7:0] knockCfg_next;
  logic [7:0] orCfg_reg;
  logic [7:0] orCfg_next;
  logic [7:0] trigCfg_reg;
  logic [7:0] trigCfg_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;

  always_comb
  begin
    knockCfg_next = knockCfg_reg;
    orCfg_next = orCfg_reg;
    trigCfg_next = trigCfg_reg;
    rdData_next = rdData_reg;
    if (regWrite)
    begin
      // Masking keeps reserved bits at zero whatever is written
      case (regAddr)
        knock_trig_pkg::KNOCK_DETECT_CONFIG_ADDR:
          knockCfg_next = regWrData & knock_trig_pkg::KNOCK_DETECT_CONFIG_MASK; // [RULE_17] [RULE_18]
        knock_trig_pkg::OVERRANGE_UNDERVOLTAGE_CONFIG_ADDR:
          orCfg_next = regWrData & knock_trig_pkg::OVERRANGE_UNDERVOLTAGE_CONFIG_MASK; // [RULE_18]
        knock_trig_pkg::CONVERSION_TRIGGER_FILTER_CONFIG_ADDR:
          trigCfg_next = regWrData & knock_trig_pkg::CONVERSION_TRIGGER_FILTER_CONFIG_MASK;
        default:
          knockCfg_next = knockCfg_reg;
      endcase
    end
    if (regRead)
    begin
      case (regAddr)
        knock_trig_pkg::KNOCK_DETECT_CONFIG_ADDR:
          rdData_next = knockCfg_reg;
        knock_trig_pkg::OVERRANGE_UNDERVOLTAGE_CONFIG_ADDR:
          rdData_next = orCfg_reg;
        knock_trig_pkg::CONVERSION_TRIGGER_FILTER_CONFIG_ADDR:
          rdData_next = trigCfg_reg;
        default:
          rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      knockCfg_reg <= knock_trig_pkg::KNOCK_DETECT_CONFIG_RESET; // [RULE_17]
      orCfg_reg <= knock_trig_pkg::OVERRANGE_UNDERVOLTAGE_CONFIG_RESET;
      trigCfg_reg <= knock_trig_pkg::CONVERSION_TRIGGER_FILTER_CONFIG_RESET;
      rdData_reg <= 8'h00;
    end
    else
    begin
      knockCfg_reg <= knockCfg_next;
      orCfg_reg <= orCfg_next;
      trigCfg_reg <= trigCfg_next;
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic [1:0] knockAxis;
  logic [1:0] overrangeOutputSelect;
  logic overrangeDetectorOff;
  logic overrangeProtectionOff;
  logic conversionTriggerExternal;
  logic conversionTriggerSource;
  logic roundingMode;
  logic firstStageRateSelect;
  logic secondStageDecimatorBypass;
  logic overrangeEvent;

  assign knockAxis = knockCfg_reg[knock_trig_pkg::KNOCK_AXIS_LSB +: 2];
  assign overrangeOutputSelect = orCfg_reg[knock_trig_pkg::OVERRANGE_OUTPUT_SELECT_LSB +: 2];
  assign overrangeDetectorOff = orCfg_reg[knock_trig_pkg::OVERRANGE_DETECTOR_OFF_BIT];
  assign overrangeProtectionOff = orCfg_reg[knock_trig_pkg::OVERRANGE_PROTECTION_OFF_BIT];
  assign conversionTriggerExternal = trigCfg_reg[knock_trig_pkg::CONVERSION_TRIGGER_EXTERNAL_BIT];
  assign conversionTriggerSource = trigCfg_reg[knock_trig_pkg::CONVERSION_TRIGGER_SOURCE_BIT];
  assign roundingMode = trigCfg_reg[knock_trig_pkg::ROUNDING_MODE_BIT];
  assign firstStageRateSelect = trigCfg_reg[knock_trig_pkg::FIRST_STAGE_RATE_SELECT_BIT];
  assign secondStageDecimatorBypass =
    trigCfg_reg[knock_trig_pkg::SECOND_STAGE_DECIMATOR_BYPASS_BIT];

  // Code 11 selects no axis, so knock watching goes quiet rather than guess
  always_comb
  begin
    case (knockAxis) // [RULE_01]
      knock_trig_pkg::KNOCK_AXIS_X: knockAxisSelect = 3'h1;
      knock_trig_pkg::KNOCK_AXIS_Y: knockAxisSelect = 3'h2;
      knock_trig_pkg::KNOCK_AXIS_Z: knockAxisSelect = 3'h4;
      default: knockAxisSelect = 3'h0;
    endcase
  end

  assign tripleKnockEnable = knockCfg_reg[knock_trig_pkg::TRIPLE_KNOCK_ENABLE_BIT]; // [RULE_02]
  assign undervoltageDetectEnable =
    ~orCfg_reg[knock_trig_pkg::UNDERVOLTAGE_DETECTOR_OFF_BIT]; // [RULE_03]
  assign overrangeEvent = overrangeRaw & ~overrangeDetectorOff; // [RULE_04]

  // ----------------------------------------------------------------
  // Overrange handling of the sample stream
  // ----------------------------------------------------------------
  logic overrangeFlag_reg;
  logic overrangeFlag_next;
  logic excitationOff_reg;
  logic excitationOff_next;
  logic [15:0] sampleOut_reg;
  logic [15:0] sampleOut_next;
  logic [15:0] lastGood_reg;
  logic [15:0] lastGood_next;
  logic sampleOutValid_reg;
  logic sampleOutValid_next;

  always_comb
  begin
    overrangeFlag_next = overrangeEvent;
    excitationOff_next = overrangeEvent & ~overrangeProtectionOff; // [RULE_05]
    sampleOut_next = sampleOut_reg;
    lastGood_next = lastGood_reg;
    sampleOutValid_next = sampleValid;
    if (sampleValid)
    begin
      sampleOut_next = sampleIn;
      if (!overrangeEvent)
      begin
        lastGood_next = sampleIn;
      end
      else if (!pdmMode) // [RULE_07]
      begin
        case (overrangeOutputSelect) // [RULE_06]
          knock_trig_pkg::OVERRANGE_OUT_FULL_SCALE:
            sampleOut_next = sampleIn[15] ? knock_trig_pkg::FULL_SCALE_NEGATIVE
                                          : knock_trig_pkg::FULL_SCALE_POSITIVE;
          knock_trig_pkg::OVERRANGE_OUT_HOLD:
            sampleOut_next = lastGood_reg;
          default:
            sampleOut_next = sampleIn;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      overrangeFlag_reg <= 1'b0;
      excitationOff_reg <= 1'b0;
      sampleOut_reg <= 16'h0000;
      lastGood_reg <= 16'h0000;
      sampleOutValid_reg <= 1'b0;
    end
    else
    begin
      overrangeFlag_reg <= overrangeFlag_next;
      excitationOff_reg <= excitationOff_next;
      sampleOut_reg <= sampleOut_next;
      lastGood_reg <= lastGood_next;
      sampleOutValid_reg <= sampleOutValid_next;
    end
  end

  assign overrangeFlag = overrangeFlag_reg;
  assign excitationOff = excitationOff_reg;
  assign sampleOut = sampleOut_reg;
  assign sampleOutValid = sampleOutValid_reg;

  // ----------------------------------------------------------------
  // Decimation and filter controls
  // ----------------------------------------------------------------
  assign firstStageRatio = firstStageRateSelect ? knock_trig_pkg::FIRST_STAGE_RATIO_FAST
                                                : knock_trig_pkg::FIRST_STAGE_RATIO_SLOW; // [RULE_09]
  assign secondStageOn = ~firstStageRateSelect & ~secondStageDecimatorBypass; // [RULE_08] [RULE_09]
  assign odrFactor = firstStageRateSelect ? knock_trig_pkg::ODR_FACTOR_FAST_FIRST // [RULE_10]
                   : secondStageDecimatorBypass ? knock_trig_pkg::ODR_FACTOR_SECOND_BYPASS
                   : knock_trig_pkg::ODR_FACTOR_DEFAULT; // [RULE_08]
  assign recursiveFilterActive =
    trigCfg_reg[knock_trig_pkg::FIRST_ORDER_RECURSIVE_FILTER_ENABLE_BIT] & ~lowpassPathSelect
    & ((highPerformanceMode & equalizerSkip) | reducedBandwidthMode | lowPowerMode); // [RULE_11]

  // ----------------------------------------------------------------
  // High-pass output narrowing
  // ----------------------------------------------------------------
  logic [15:0] hpfTrunc;
  logic [15:0] hpfOut_reg;
  logic [15:0] hpfOut_next;
  logic hpfOutValid_reg;
  logic hpfOutValid_next;

  assign hpfTrunc = hpfIn[HPF_WIDTH-1 -: 16];

  // A negative value never overflows on +1, so no saturation is needed
  always_comb
  begin
    hpfOut_next = hpfOut_reg;
    hpfOutValid_next = hpfValid;
    if (hpfValid)
    begin
      hpfOut_next = hpfTrunc; // [RULE_12]
      if (roundingMode && hpfIn[HPF_WIDTH-1])
      begin
        hpfOut_next = hpfTrunc + 16'h0001; // [RULE_13]
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hpfOut_reg <= 16'h0000;
      hpfOutValid_reg <= 1'b0;
    end
    else
    begin
      hpfOut_reg <= hpfOut_next;
      hpfOutValid_reg <= hpfOutValid_next;
    end
  end

  assign hpfOut = hpfOut_reg;
  assign hpfOutValid = hpfOutValid_reg;

  // ----------------------------------------------------------------
  // Conversion start
  // ----------------------------------------------------------------
  logic internalTick;
  logic selectedPin;
  logic externalEdge;
  logic pinPrev_reg;
  logic pinPrev_next;
  logic convStart_reg;
  logic convStart_next;

  conversion_tick_divider #(
    .PERIOD_CYCLES(CONVERSION_CYCLES)
  ) u_divider (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .enable(~conversionTriggerExternal),
    .tick(internalTick)
  );

  assign selectedPin = conversionTriggerSource ? firstInterruptPin : frameSyncPin; // [RULE_14]
  assign externalEdge = selectedPin & ~pinPrev_reg;

  always_comb
  begin
    pinPrev_next = selectedPin;
    convStart_next = conversionTriggerExternal ? externalEdge // [RULE_16]
                                               : internalTick; // [RULE_15]
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinPrev_reg <= 1'b0;
      convStart_reg <= 1'b0;
    end
    else
    begin
      pinPrev_reg <= pinPrev_next;
      convStart_reg <= convStart_next;
    end
  end

  assign conversionStart = convStart_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  AST_RESERVED_READ_ZERO: assert property ( // [RULE_18]
    regRead && regAddr == knock_trig_pkg::OVERRANGE_UNDERVOLTAGE_CONFIG_ADDR
    |=> regRdData[7:5] == 3'h0)
    else $error("Reserved overrange config bits read nonzero");

  AST_AXIS_Z: assert property ( // [RULE_01]
    regWrite && regAddr == knock_trig_pkg::KNOCK_DETECT_CONFIG_ADDR && regWrData[1:0] == 2'h2
    |=> knockAxisSelect == 3'h4)
    else $error("Axis code 10 did not select Z");

  AST_TRIPLE_FOLLOWS_WRITE: assert property ( // [RULE_02]
    regWrite && regAddr == knock_trig_pkg::KNOCK_DETECT_CONFIG_ADDR
    |=> tripleKnockEnable == $past(regWrData[2]))
    else $error("Triple knock enable did not follow write");

  AST_UV_OFF: assert property ( // [RULE_03]
    regWrite && regAddr == knock_trig_pkg::OVERRANGE_UNDERVOLTAGE_CONFIG_ADDR
    |=> undervoltageDetectEnable == !$past(regWrData[4]))
    else $error("Undervoltage enable wrong after write");

  AST_DETECT_OFF_SILENT: assert property ( // [RULE_04]
    overrangeDetectorOff && $past(overrangeDetectorOff) |-> !overrangeFlag && !excitationOff)
    else $error("Overrange seen while detector off");

  AST_PROTECT_OFF: assert property ( // [RULE_05]
    overrangeRaw && !overrangeDetectorOff && overrangeProtectionOff
    |=> overrangeFlag && !excitationOff)
    else $error("Excitation cut while protection off");

  AST_FULL_SCALE: assert property ( // [RULE_06]
    sampleValid && overrangeEvent && !pdmMode
    && overrangeOutputSelect == knock_trig_pkg::OVERRANGE_OUT_FULL_SCALE
    |=> sampleOut == ($past(sampleIn[15]) ? 16'h8000 : 16'h7fff) && sampleOutValid)
    else $error("Full scale substitution wrong");

  AST_PDM_PASS: assert property ( // [RULE_07]
    sampleValid && pdmMode |=> sampleOut == $past(sampleIn))
    else $error("Sample altered in PDM mode");

  AST_FAST_RATE: assert property ( // [RULE_10]
    firstStageRateSelect |-> odrFactor == 3'h4 && !secondStageOn && firstStageRatio == 6'h10)
    else $error("Fast first stage settings wrong");

  AST_ROUND_NEG: assert property ( // [RULE_13]
    hpfValid && roundingMode && hpfIn[HPF_WIDTH-1]
    |=> hpfOut == $past(hpfTrunc) + 16'h0001)
    else $error("Negative high-pass value not rounded");

  AST_START_SOURCE: assert property ( // [RULE_15]
    conversionStart |-> ($past(conversionTriggerExternal) ? $past(externalEdge)
                                                         : $past(internalTick)))
    else $error("Conversion start from wrong source");
endmodule

// ==== testbench/trigger_pin_source.sv ====
`timescale 1ns/1ps
module trigger_pin_source (
  input wire logic sys_clk,
  output logic frameSyncPin,
  output logic firstInterruptPin
);
  initial
  begin
    frameSyncPin = 1'h0;
    firstInterruptPin = 1'h0;
  end

  // High for one cycle, then low for one, so each call is a fresh edge
  task automatic pulse(input logic useInt);
    if (useInt)
      firstInterruptPin = 1'h1;
    else
      frameSyncPin = 1'h1;
    @(negedge sys_clk);
    frameSyncPin = 1'h0;
    firstInterruptPin = 1'h0;
    @(negedge sys_clk);
  endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, sys_rst, regWrite, regRead, overrangeRaw, pdmMode, sampleValid, hpfValid;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [2:0] knockAxisSelect, odrFactor;
  logic tripleKnockEnable, undervoltageDetectEnable, overrangeFlag, excitationOff;
  logic sampleOutValid, secondStageOn, recursiveFilterActive, hpfOutValid, conversionStart;
  logic highPerformanceMode, reducedBandwidthMode, lowPowerMode, equalizerSkip;
  logic lowpassPathSelect, frameSyncPin, firstInterruptPin;
  logic [15:0] sampleIn, sampleOut, hpfOut, e;
  logic [5:0] firstStageRatio;
  logic [23:0] hpfIn;
  int errors = 0, checksDone = 0, cycles = 0, starts = 0, base = 0;

  // Short internal period keeps the trigger tests brief
  knock_overrange_trigger_config #(.CONVERSION_CYCLES(4)) knock_overrange_trigger_config_i (
    .sys_clk, .sys_rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .knockAxisSelect, .tripleKnockEnable, .undervoltageDetectEnable, .overrangeRaw,
    .overrangeFlag, .excitationOff, .pdmMode, .sampleIn, .sampleValid, .sampleOut,
    .sampleOutValid, .firstStageRatio, .secondStageOn, .odrFactor, .highPerformanceMode,
    .reducedBandwidthMode, .lowPowerMode, .equalizerSkip, .lowpassPathSelect,
    .recursiveFilterActive, .hpfIn, .hpfValid, .hpfOut, .hpfOutValid, .frameSyncPin,
    .firstInterruptPin, .conversionStart);

  trigger_pin_source trigger_pin_source_i (.sys_clk, .frameSyncPin, .firstInterruptPin);

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (conversionStart === 1'h1)
      starts <= starts + 1;
    // Timeout counts as one mismatch, passed in so only the checker writes errors
    if (cycles == 5000)
    begin
      wrap_up(1);
    end
  end

  task automatic wrap_up(input int late);
    $display("checks %0d errors %0d", checksDone, errors + late);
    if (errors + late == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Each strobe is followed by an idle cycle so back-to-back calls never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrite = 1'h1;
    @(negedge sys_clk);
    regWrite = 1'h0;
    @(negedge sys_clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    regRead = 1'h1;
    @(negedge sys_clk);
    regRead = 1'h0;
    check(16'(regRdData), 16'(exp));
    @(negedge sys_clk);
  endtask

  // Flag pair expected as {overrangeFlag, excitationOff}
  task automatic samp(input logic [15:0] d, input logic raw, input logic [15:0] exp,
    input logic [1:0] fe);
    sampleIn = d;
    overrangeRaw = raw;
    sampleValid = 1'h1;
    @(negedge sys_clk);
    sampleValid = 1'h0;
    overrangeRaw = 1'h0;
    check(sampleOut, exp);
    check(16'({sampleOutValid, overrangeFlag, excitationOff}), 16'({1'h1, fe}));
    @(negedge sys_clk);
  endtask

  task automatic hp(input logic [23:0] d, input logic [15:0] exp);
    hpfIn = d;
    hpfValid = 1'h1;
    @(negedge sys_clk);
    hpfValid = 1'h0;
    check(hpfOut, exp);
    check(16'(hpfOutValid), 16'h1);
    @(negedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {sys_rst, regWrite, regRead, overrangeRaw, pdmMode, sampleValid, hpfValid} = 7'h40;
    {regAddr, regWrData, sampleIn, hpfIn} = 56'h0;
    {highPerformanceMode, reducedBandwidthMode, lowPowerMode} = 3'h0;
    {equalizerSkip, lowpassPathSelect} = 2'h0;
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'h0;
    @(negedge sys_clk);
    rdc(8'h47, 8'h00);
    rdc(8'h48, 8'h00);
    rdc(8'h49, 8'h00);
    $display("test reset done");

    // Bit 0 of the trigger register stays clear to keep internal starts
    wr(8'h47, 8'hff);
    wr(8'h48, 8'hff);
    wr(8'h49, 8'hfe);
    wr(8'h4a, 8'hff);
    rdc(8'h47, 8'h07);
    rdc(8'h48, 8'h1f);
    rdc(8'h49, 8'he6);
    rdc(8'h4a, 8'h00);
    check(16'({tripleKnockEnable, undervoltageDetectEnable}), 16'h2);
    wr(8'h48, 8'h00);
    check(16'(undervoltageDetectEnable), 16'h1);
    $display("test reserved done");

    for (int i = 0; i < 4; i++)
    begin
      wr(8'h47, 8'(i));
      e = (i < 3) ? 16'(1 << i) : 16'h0;
      check(16'({tripleKnockEnable, knockAxisSelect}), e);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h49, 8'(i << 6));
      e = {6'h0, i[0] ? 6'h10 : 6'h20, i == 0, i[0] ? 3'h4 : (i[1] ? 3'h2 : 3'h1)};
      check(16'({firstStageRatio, secondStageOn, odrFactor}), e);
    end
    for (int i = 0; i < 64; i++)
    begin
      {highPerformanceMode, reducedBandwidthMode, lowPowerMode} = i[4:2];
      {equalizerSkip, lowpassPathSelect} = i[1:0];
      wr(8'h49, {2'h0, i[5], 5'h0});
      e = 16'(i[5] & ~i[0] & ((i[4] & i[1]) | i[3] | i[2]));
      check(16'(recursiveFilterActive), e);
    end
    $display("test modes done");

    // The held value is the last sample taken without an event
    samp(16'h1234, 1'h0, 16'h1234, 2'h0);
    samp(16'h9000, 1'h1, 16'h8000, 2'h3);
    samp(16'h1000, 1'h1, 16'h7fff, 2'h3);
    wr(8'h48, 8'h01);
    samp(16'h2222, 1'h1, 16'h1234, 2'h3);
    wr(8'h48, 8'h02);
    samp(16'h3333, 1'h1, 16'h3333, 2'h3);
    wr(8'h48, 8'h04);
    samp(16'h9000, 1'h1, 16'h8000, 2'h2);
    wr(8'h48, 8'h08);
    samp(16'h9000, 1'h1, 16'h9000, 2'h0);
    wr(8'h48, 8'h00);
    pdmMode = 1'h1;
    samp(16'h9000, 1'h1, 16'h9000, 2'h3);
    pdmMode = 1'h0;
    $display("test overrange done");

    wr(8'h49, 8'h00);
    hp(24'hfffff0, 16'hffff);
    hp(24'h123456, 16'h1234);
    wr(8'h49, 8'h04);
    hp(24'hfffff0, 16'h0000);
    hp(24'h8001ff, 16'h8002);
    hp(24'h1234ff, 16'h1234);
    $display("test rounding done");

    // Pins pulse inside a 40-cycle window; only the divider may count
    wr(8'h49, 8'h00);
    repeat (8) @(negedge sys_clk);
    base = starts;
    trigger_pin_source_i.pulse(1'h0);
    trigger_pin_source_i.pulse(1'h1);
    repeat (36) @(negedge sys_clk);
    check(16'(starts - base), 16'h000a);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h49, {6'h0, i[1], 1'h1});
      repeat (2) @(negedge sys_clk);
      base = starts;
      trigger_pin_source_i.pulse(i[0]);
      repeat (3) @(negedge sys_clk);
      check(16'(starts - base), 16'(i[1] == i[0]));
    end
    $display("test trigger done");
    wrap_up(0);
  end
endmodule
